// ---- logic/psw_cdc_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Small dual-clock buffer with gray-coded pointers
module psw_cdc_fifo #(
  parameter int WIDTH = 50,
  parameter int DEPTH = psw_pkg::PSW_BUF_DEPTH_DEF
) (
  input wire logic w_clk,
  input wire logic w_rst_n,
  input wire logic [WIDTH-1:0] w_data,
  input wire logic w_valid,
  output logic w_ready,
  input wire logic r_clk,
  input wire logic r_rst_n,
  input wire logic r_en,
  output logic [WIDTH-1:0] r_data,
  output logic r_valid,
  input wire logic r_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ========================================================================
  // Elaboration check
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [AW:0] from_gray(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    // Top bit first, so no index ever runs past the pointer
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wbin_r, wgray_r, rbin_r, rgray_r;
  logic [AW:0] rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
  wire logic [AW:0] rbin_at_w = from_gray(rg_s2_r);
  wire logic [AW:0] wbin_at_r = from_gray(wg_s2_r);
  wire logic full_w = (wbin_r[AW] != rbin_at_w[AW]) && (wbin_r[AW-1:0] == rbin_at_w[AW-1:0]);
  wire logic push = w_valid && w_ready;
  wire logic pop = r_en && r_valid && r_ready;
  wire logic [AW:0] wbin_nxt = wbin_r + (AW+1)'(1);
  wire logic [AW:0] rbin_nxt = rbin_r + (AW+1)'(1);

  // Full is pessimistic while the read pointer is still crossing
  assign w_ready = !full_w;
  assign r_valid = (wbin_at_r != rbin_r);
  assign r_data = mem_r[rbin_r[AW-1:0]];

  // ========================================================================
  // Write side
  always_ff @(posedge w_clk or negedge w_rst_n) begin
    if (!w_rst_n) begin
      wbin_r <= '0;
      wgray_r <= '0;
    end else if (push) begin
      wbin_r <= wbin_nxt;
      wgray_r <= to_gray(wbin_nxt);
    end
  end

  // Storage: no reset needed, only written words are ever read
  always_ff @(posedge w_clk) begin
    if (push) begin
      mem_r[wbin_r[AW-1:0]] <= w_data;
    end
  end

  // Read pointer into the write domain
  always_ff @(posedge w_clk or negedge w_rst_n) begin
    if (!w_rst_n) begin
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end else begin
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
    end
  end

  // ========================================================================
  // Read side, frozen with the enable
  always_ff @(posedge r_clk or negedge r_rst_n) begin
    if (!r_rst_n) begin
      rbin_r <= '0;
      rgray_r <= '0;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else if (r_en) begin
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
      if (pop) begin
        rbin_r <= rbin_nxt;
        rgray_r <= to_gray(rbin_nxt);
      end
    end
  end

  AST_FIFO_FULL_BLOCKS: assert property (@(posedge w_clk) disable iff (!w_rst_n)
    full_w |=> $stable(wbin_r))
    else $error("write pointer moved while full");

endmodule
`default_nettype wire

// ---- logic/psw_pkg.sv ----
`default_nettype none
// ==========================================================================
// Shared constants and types for the masked write path
package psw_pkg;

  // Command/address word layout (three 16-bit words, 48 bits)
  localparam int PSW_CA_WORDS = 3;
  localparam int PSW_CA_W = 48;
  localparam int PSW_CA_RW_BIT = 47;
  localparam int PSW_CA_SPACE_BIT = 46;
  localparam int PSW_CA_ROW_MSB = 44;
  localparam int PSW_CA_ROW_LSB = 16;
  localparam int PSW_CA_COL_MSB = 2;

  // Data path widths
  localparam int PSW_ADDR_W = 32;
  localparam int PSW_WORD_W = 16;
  localparam int PSW_MASK_W = 2;
  localparam int PSW_CNT_W = 8;

  // Defaults of tunable figures
  localparam int PSW_LAT_COUNT_DEF = 6;
  localparam int PSW_BUF_DEPTH_DEF = 2;

  // Reset values of driven pins
  localparam logic [7:0] PSW_DQ_RST = 8'h00;
  localparam logic PSW_STRB_RST = 1'b0;

  // Link-side phase of a transaction
  typedef enum logic [1:0] {
    PSW_ST_CA,
    PSW_ST_LAT,
    PSW_ST_DATA,
    PSW_ST_SKIP
  } psw_state_t;

  // One word heading for the array, keep bit set = byte is written
  typedef struct packed {
    logic [PSW_ADDR_W-1:0] addr;
    logic [PSW_WORD_W-1:0] data;
    logic [PSW_MASK_W-1:0] keep;
  } psw_word_t;

endpackage
`default_nettype wire

// ---- logic/psw_write_path.sv ----
// Contract
// - In the command phase the host drives the address bytes and the device drives the strobe.
// - In the command phase the device's strobe level tells whether extra latency applies.
// - The device releases the strobe once the last command cycle is over.
// - In the data phase the strobe qualifies each byte and masked bytes stay unchanged.
// - An unaligned word write, masking the outer bytes, changes only the straddled bytes.
// - Strobe high in the command phase means twice the latency count, low means once.
`timescale 1ns/100ps
`default_nettype none
module psw_write_path #(
  parameter int LAT_COUNT = psw_pkg::PSW_LAT_COUNT_DEF,
  parameter int BUF_DEPTH = psw_pkg::PSW_BUF_DEPTH_DEF
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic bus_clk,
  input wire logic clock_complement,
  input wire logic cs_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic rd_wr_strobe_in,
  output logic rd_wr_strobe_out,
  output logic rd_wr_strobe_oe,
  input wire logic refresh_busy,
  output logic wr_valid,
  output logic [psw_pkg::PSW_ADDR_W-1:0] wr_addr,
  output logic [psw_pkg::PSW_WORD_W-1:0] wr_data,
  output logic [psw_pkg::PSW_MASK_W-1:0] wr_byte_en,
  input wire logic wr_ready,
  output logic write_dropped
);

  // ========================================================================
  // Elaboration check
  if (LAT_COUNT < 1 || LAT_COUNT > 127) begin : g_bad_lat
    $error("LAT_COUNT must lie in 1..127");
  end

  // ========================================================================
  // Helpers
  function automatic logic [psw_pkg::PSW_ADDR_W-1:0] ca_word_addr(
    input logic [psw_pkg::PSW_CA_W-1:0] ca);
    return {ca[psw_pkg::PSW_CA_ROW_MSB:psw_pkg::PSW_CA_ROW_LSB],
            ca[psw_pkg::PSW_CA_COL_MSB:0]};
  endfunction

  function automatic logic [psw_pkg::PSW_CNT_W-1:0] lat_len(input logic dbl);
    return dbl ? psw_pkg::PSW_CNT_W'(2 * LAT_COUNT) : psw_pkg::PSW_CNT_W'(LAT_COUNT);
  endfunction

  // ========================================================================
  // Link clocks and frame reset
  // The frame's own select ends it, since the bus clock may stop
  wire logic bus_clk_fall = ~bus_clk;
  wire logic frame_rst_n = arst_n & ~cs_n;

  psw_pkg::psw_state_t state_r, state_nxt;
  logic [psw_pkg::PSW_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [psw_pkg::PSW_CA_W-1:0] ca_r;
  logic [psw_pkg::PSW_ADDR_W-1:0] addr_r;
  logic [7:0] rise_byte_r;
  logic rise_strb_r;
  logic busy_s1_r, busy_s2_r;
  logic seen_r, dbl_r;
  logic strb_out_r, strb_oe_r;
  logic [7:0] dq_out_r;
  logic dq_oe_r;
  logic drop_r;

  // ========================================================================
  // Rising-edge side: first byte of each word, strobe drive
  // Busy level from the system side, two stages on the link clock
  always_ff @(posedge bus_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
    end else begin
      busy_s1_r <= refresh_busy;
      busy_s2_r <= busy_s1_r;
    end
  end

  // First byte and its strobe level
  always_ff @(posedge bus_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rise_byte_r <= 8'h00;
      rise_strb_r <= 1'b0;
    end else begin
      rise_byte_r <= dq_in;
      rise_strb_r <= rd_wr_strobe_in;
    end
  end

  // Latency choice frozen at the first edge of the frame
  always_ff @(posedge bus_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      seen_r <= 1'b0;
      dbl_r <= 1'b0;
      strb_out_r <= psw_pkg::PSW_STRB_RST;
      strb_oe_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
      if (!seen_r) begin
        dbl_r <= busy_s2_r;
        strb_out_r <= busy_s2_r;
      end
      strb_oe_r <= (state_r == psw_pkg::PSW_ST_CA);
    end
  end

  // Data lines are never driven on a write path
  always_ff @(posedge bus_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_out_r <= psw_pkg::PSW_DQ_RST;
      dq_oe_r <= 1'b0;
    end else begin
      dq_out_r <= psw_pkg::PSW_DQ_RST;
      dq_oe_r <= 1'b0;
    end
  end

  assign rd_wr_strobe_out = strb_out_r;
  assign rd_wr_strobe_oe = strb_oe_r;
  assign dq_out = dq_out_r;
  assign dq_oe = dq_oe_r;

  // ========================================================================
  // Falling-edge side: whole words, phase sequencing
  // First byte sits in the high half of the word
  wire logic [psw_pkg::PSW_WORD_W-1:0] word_w = {rise_byte_r, dq_in};
  wire logic [psw_pkg::PSW_MASK_W-1:0] mask_w = {rise_strb_r, rd_wr_strobe_in};
  wire logic [psw_pkg::PSW_CA_W-1:0] ca_nxt = {ca_r[psw_pkg::PSW_CA_W-17:0], word_w};
  wire logic ca_last = (cnt_r == psw_pkg::PSW_CNT_W'(psw_pkg::PSW_CA_WORDS - 1));
  wire logic ca_is_mem_wr = !ca_nxt[psw_pkg::PSW_CA_RW_BIT] && !ca_nxt[psw_pkg::PSW_CA_SPACE_BIT];
  wire logic lat_last = (cnt_r == lat_len(dbl_r) - psw_pkg::PSW_CNT_W'(1));
  wire logic [psw_pkg::PSW_MASK_W-1:0] keep_w = ~mask_w;
  wire logic in_data = (state_r == psw_pkg::PSW_ST_DATA);
  wire logic push_w = in_data && (keep_w != '0);
  wire logic push_ready;
  psw_pkg::psw_word_t push_item;

  // Masked bytes travel with keep low so the array leaves them alone
  assign push_item = '{addr: addr_r, data: word_w, keep: keep_w};

  // Next phase; reads and register writes are left to other logic
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      psw_pkg::PSW_ST_CA: begin
        cnt_nxt = cnt_r + psw_pkg::PSW_CNT_W'(1);
        if (ca_last) begin
          cnt_nxt = '0;
          state_nxt = ca_is_mem_wr ? psw_pkg::PSW_ST_LAT : psw_pkg::PSW_ST_SKIP;
        end
      end
      psw_pkg::PSW_ST_LAT: begin
        cnt_nxt = cnt_r + psw_pkg::PSW_CNT_W'(1);
        if (lat_last) begin
          cnt_nxt = '0;
          state_nxt = psw_pkg::PSW_ST_DATA;
        end
      end
      psw_pkg::PSW_ST_DATA: state_nxt = psw_pkg::PSW_ST_DATA;
      psw_pkg::PSW_ST_SKIP: state_nxt = psw_pkg::PSW_ST_SKIP;
      default: state_nxt = psw_pkg::PSW_ST_SKIP;
    endcase
  end

  // Phase registers, command word and running address
  always_ff @(posedge bus_clk_fall or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state_r <= psw_pkg::PSW_ST_CA;
      cnt_r <= '0;
      ca_r <= '0;
      addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (state_r == psw_pkg::PSW_ST_CA) begin
        ca_r <= ca_nxt;
        addr_r <= ca_word_addr(ca_nxt);
      end else if (in_data) begin
        addr_r <= addr_r + psw_pkg::PSW_ADDR_W'(1);
      end
    end
  end

  // Host cannot be stalled; a word meeting a full buffer is flagged
  always_ff @(posedge bus_clk_fall or negedge arst_n) begin
    if (!arst_n) begin
      drop_r <= 1'b0;
    end else if (push_w && !push_ready) begin
      drop_r <= 1'b1;
    end
  end

  // ========================================================================
  // Crossing buffer
  psw_pkg::psw_word_t pop_item;
  logic pop_valid;
  logic wr_valid_r;
  wire logic out_free = !wr_valid_r || wr_ready;
  wire logic pop_w = clk_en && pop_valid && out_free;

  psw_cdc_fifo #(
    .WIDTH($bits(psw_pkg::psw_word_t)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .w_clk(bus_clk_fall),
    .w_rst_n(arst_n),
    .w_data(push_item),
    .w_valid(push_w),
    .w_ready(push_ready),
    .r_clk(clock),
    .r_rst_n(arst_n),
    .r_en(clk_en),
    .r_data(pop_item),
    .r_valid(pop_valid),
    .r_ready(out_free)
  );

  // ========================================================================
  // System side output stage
  logic [psw_pkg::PSW_ADDR_W-1:0] wr_addr_r;
  logic [psw_pkg::PSW_WORD_W-1:0] wr_data_r;
  logic [psw_pkg::PSW_MASK_W-1:0] wr_be_r;
  logic drop_s1_r, drop_s2_r;

  // Word holds until taken; a stalled array backs up into the buffer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_valid_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
      wr_be_r <= '0;
    end else if (clk_en) begin
      if (pop_w) begin
        wr_valid_r <= 1'b1;
        wr_addr_r <= pop_item.addr;
        wr_data_r <= pop_item.data;
        wr_be_r <= pop_item.keep;
      end else if (wr_ready) begin
        wr_valid_r <= 1'b0;
      end
    end
  end

  // Drop flag into the system clock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      drop_s1_r <= 1'b0;
      drop_s2_r <= 1'b0;
    end else if (clk_en) begin
      drop_s1_r <= drop_r;
      drop_s2_r <= drop_s1_r;
    end
  end

  assign wr_valid = wr_valid_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;
  assign wr_byte_en = wr_be_r;
  assign write_dropped = drop_s2_r;

  // ========================================================================
  // Checks
  AST_CA_STROBE_DRIVEN: assert property (@(posedge bus_clk_fall) disable iff (!frame_rst_n)
    (state_r == psw_pkg::PSW_ST_CA) |-> strb_oe_r)
    else $error("strobe not driven in command phase");

  AST_CA_STROBE_LEVEL: assert property (@(posedge bus_clk_fall) disable iff (!frame_rst_n)
    (state_r == psw_pkg::PSW_ST_CA) |-> (strb_out_r == dbl_r))
    else $error("strobe level differs from latency choice");

  AST_STROBE_RELEASE: assert property (@(posedge bus_clk) disable iff (!frame_rst_n)
    (state_r != psw_pkg::PSW_ST_CA) |=> !strb_oe_r)
    else $error("strobe still driven after command phase");

  AST_LAT_BOUND: assert property (@(posedge bus_clk_fall) disable iff (!frame_rst_n)
    (state_r == psw_pkg::PSW_ST_LAT) |-> (cnt_r < lat_len(dbl_r)))
    else $error("latency count overran");

  AST_LAT_EXIT: assert property (@(posedge bus_clk_fall) disable iff (!frame_rst_n)
    (state_r == psw_pkg::PSW_ST_LAT) && (state_nxt == psw_pkg::PSW_ST_DATA)
      |-> (cnt_r == lat_len(dbl_r) - psw_pkg::PSW_CNT_W'(1)))
    else $error("data phase entered at wrong latency");

  AST_MASKED_NOT_PUSHED: assert property (@(posedge bus_clk_fall) disable iff (!frame_rst_n)
    in_data && (mask_w == 2'h3) |-> !push_w)
    else $error("fully masked word reached the buffer");

  AST_UNALIGNED_KEEP: assert property (@(posedge bus_clk_fall) disable iff (!frame_rst_n)
    push_w && (mask_w == 2'h2) |-> (push_item.keep == 2'h1) && (push_item.data[7:0] == dq_in))
    else $error("straddled byte not kept");

  AST_OUT_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    wr_valid_r && !wr_ready |=> wr_valid_r && $stable(wr_data_r) && $stable(wr_be_r))
    else $error("write word changed while stalled");

  COV_DOUBLE_LAT: cover property (@(posedge bus_clk_fall) disable iff (!frame_rst_n)
    dbl_r && (state_r == psw_pkg::PSW_ST_DATA));
  COV_PARTIAL_WORD: cover property (@(posedge bus_clk_fall) disable iff (!frame_rst_n)
    push_w && (keep_w != 2'h3));
  COV_STALL: cover property (@(posedge clock) disable iff (!arst_n)
    wr_valid_r && !wr_ready ##1 wr_valid_r && wr_ready);

endmodule
`default_nettype wire

// ---- testbench/psw_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Host bus controller: link clock, select, bytes and strobe
module psw_host_model #(
  parameter int LAT = 2
) (
  output logic bus_clk,
  output logic clock_complement,
  output logic cs_n,
  output logic [7:0] dq_in,
  output logic strobe_pin,
  input wire logic dev_strobe,
  input wire logic dev_strobe_oe
);
  logic [15:0] dq_w[$];
  logic [1:0] msk_w[$];
  logic host_oe = 1'b0;
  logic host_v = 1'b0;
  logic last_v = 1'b0;
  logic seen_dbl = 1'b0;
  logic err = 1'b0;

  // Undriven strobe shows the inverse of its last level, never a stale copy
  assign strobe_pin = dev_strobe_oe ? dev_strobe : (host_oe ? host_v : ~last_v);
  assign clock_complement = ~bus_clk;
  always @(bus_clk) if (dev_strobe_oe || host_oe) last_v = strobe_pin;
  // Both ends driving the strobe at once is a fight on the pin
  always @* if (dev_strobe_oe && host_oe) err = 1'b1;

  initial begin
    bus_clk = 1'b0;
    cs_n = 1'b1;
    dq_in = 8'h00;
  end

  // One byte half-centred on one clock edge
  task automatic half(input logic [7:0] b, input logic s);
    dq_in = b;
    host_v = s;
    #1.5 bus_clk = ~bus_clk;
    #1.5;
  endtask

  // Clock stands still outside frames except for these sync pulses
  task automatic idle(input int n);
    repeat (2 * n) half(~dq_in, 1'b0);
  endtask

  task automatic send(input logic [47:0] ca);
    int lat;
    logic [15:0] w;
    logic [1:0] m;
    idle(2);
    err = 1'b0;
    cs_n = 1'b0;
    for (int i = 0; i < 3; i++) begin
      half(ca[47-16*i -: 8], 1'b0);
      half(ca[39-16*i -: 8], 1'b0);
      if (dev_strobe_oe !== 1'b1) err = 1'b1;
      if (i == 0) seen_dbl = strobe_pin;
    end
    lat = seen_dbl ? 2 * LAT : LAT;
    for (int i = 0; i < lat; i++) begin
      half(~dq_in, 1'b0);
      if (i == 0) begin
        if (dev_strobe_oe !== 1'b0) err = 1'b1;
        host_oe = 1'b1;
      end
      half(~dq_in, 1'b0);
    end
    while (dq_w.size() > 0) begin
      w = dq_w.pop_front();
      m = msk_w.pop_front();
      half(w[15:8], m[1]);
      half(w[7:0], m[0]);
    end
    host_oe = 1'b0;
    cs_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- testbench/psw_write_path_test.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Bench: host model on the link, stalling array on the system side
module psw_write_path_test;
  localparam int LAT = 2;
  logic clock, arst_n, clk_en, refresh_busy, wr_ready, wr_valid, write_dropped;
  logic bus_clk, clock_complement, cs_n, strobe_pin, strobe_out, strobe_oe, dq_oe;
  logic [7:0] dq_in, dq_out;
  logic [psw_pkg::PSW_ADDR_W-1:0] wr_addr;
  logic [psw_pkg::PSW_WORD_W-1:0] wr_data;
  logic [psw_pkg::PSW_MASK_W-1:0] wr_byte_en;
  psw_pkg::psw_word_t exp_q[$];
  psw_pkg::psw_word_t got;
  int n_fail, checked, stall_mode;

  psw_write_path #(.LAT_COUNT(LAT), .BUF_DEPTH(2)) dut (.clock(clock), .arst_n(arst_n),
    .clk_en(clk_en), .bus_clk(bus_clk), .clock_complement(clock_complement), .cs_n(cs_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .rd_wr_strobe_in(strobe_pin),
    .rd_wr_strobe_out(strobe_out), .rd_wr_strobe_oe(strobe_oe),
    .refresh_busy(refresh_busy), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_byte_en(wr_byte_en), .wr_ready(wr_ready),
    .write_dropped(write_dropped));
  psw_host_model #(.LAT(LAT)) host (.bus_clk(bus_clk), .clock_complement(clock_complement),
    .cs_n(cs_n), .dq_in(dq_in), .strobe_pin(strobe_pin), .dev_strobe(strobe_out),
    .dev_strobe_oe(strobe_oe));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Array side: random stalls (0), held stall (1), open (2); random enable gaps in every mode
  always @(posedge clock) begin
    #1;
    wr_ready <= (stall_mode == 0) ? ($urandom % 3 != 0) : (stall_mode == 2);
    clk_en <= ($urandom % 4 != 0);
  end

  // Every taken word must be the next one predicted
  always @(posedge clock) begin
    if (arst_n && clk_en && wr_valid && wr_ready) begin
      got = {wr_addr, wr_data, wr_byte_en};
      if (exp_q.size() == 0) check(64'(got), '1);
      else check(64'(got), 64'(exp_q.pop_front()));
    end
  end

  function automatic logic [47:0] rand_ca(input logic [1:0] sp);
    return {sp, 1'b1, 29'($urandom), 13'h0, 3'($urandom)};
  endfunction

  // Kind 0 random masks, 1 unaligned outer bytes masked, 2 all bytes kept
  task automatic frame(input logic [47:0] ca, input int n, input int kind);
    logic [15:0] d;
    logic [1:0] m;
    psw_pkg::psw_word_t e;
    for (int k = 0; k < n; k++) begin
      d = 16'($urandom);
      m = (kind == 2) ? 2'h0 : 2'($urandom);
      if (kind == 1) m = (k == 0) ? 2'h2 : ((k == n - 1) ? 2'h1 : 2'h0);
      host.dq_w.push_back(d);
      host.msk_w.push_back(m);
      e = {{ca[44:16], ca[2:0]} + 32'(k), d, ~m};
      if (ca[47:46] == 2'h0 && m != 2'h3) exp_q.push_back(e);
    end
    host.send(ca);
    for (int t = 0; t < 200 && exp_q.size() > 0 && stall_mode != 1; t++) @(posedge clock);
    if (exp_q.size() > 0 && stall_mode != 1) begin
      check(64'(exp_q.size()), 64'h0);
      end_sim();
    end
    if (ca[47:46] == 2'h0) check(64'(host.err), 64'h0);
    check(64'(host.seen_dbl), 64'(refresh_busy));
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    host.idle(2);
    repeat (3) @(posedge clock);
    #1 arst_n = 1'b1;
  endtask

  initial begin
    n_fail = 0;
    checked = 0;
    stall_mode = 0;
    clk_en = 1'b1;
    wr_ready = 1'b0;
    refresh_busy = 1'b0;
    void'($urandom(32'h9C5C));
    do_reset();
    // Back-to-back short frames, single and double latency, stalls throughout
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      #1 refresh_busy = 1'(i % 2);
      frame(rand_ca(2'h0), 2, (i < 4) ? 0 : 1);
    end
    $display("test masked_writes done");
    // Read and register frames hand nothing to the array
    for (int i = 1; i < 4; i++) frame(rand_ca(2'(i)), 2, 0);
    $display("test refused_frames done");
    // Held stall: buffer fills, late words are lost and flagged
    stall_mode = 1;
    frame(rand_ca(2'h0), 6, 2);
    // Flag needs two enabled system clocks to cross over
    repeat (12) @(posedge clock);
    check(64'(write_dropped), 64'h1);
    stall_mode = 2;
    repeat (40) @(posedge clock);
    exp_q.delete();
    $display("test overflow done");
    // Mid-run reset clears the flag, then an unaligned write still lands
    do_reset();
    check(64'(write_dropped), 64'h0);
    stall_mode = 0;
    frame(rand_ca(2'h0), 2, 1);
    check(64'(dq_oe), 64'h0);
    check(64'(dq_out), 64'h0);
    $display("test reset_rerun done");
    end_sim();
  end
endmodule
`default_nettype wire
